// ---- testbench/fct_cpu_model.sv ----
`timescale 1ns/10ps
// stands in for the cpu on the byte register port
module fct_cpu_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one byte access over one rising edge; idle lines show inverted values
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = ~w;
    @(negedge i_clk);
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // upper byte first, lower on the very next edge with the strobe held
  task automatic pair(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d[15:8];
    o_wr = w;
    o_rd = ~w;
    @(negedge i_clk);
    q[15:8] = i_rdata;
    o_addr = a + 4'h1;
    o_wdata = d[7:0];
    @(negedge i_clk);
    q[7:0] = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d[7:0];
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    logic [15:0] q;
    pair(1'b1, a, v, q);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    pair(1'b0, a, 16'h0000, v);
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import fct_pkg::*;
  logic i_clk, i_rstn, i_standby, i_ext, i_cap, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, ie, fl;
  logic pin_a, pin_b, irq_c, irq_a, irq_b, irq_w;
  logic [31:0] seed = 32'hb568;
  logic [31:0] r;
  logic [15:0] s, ca, cb, q16;
  logic [18:0] x;
  logic clr, la, lb, e, hit, exp_pa, exp_pb;
  int n;
  int err_total = 0;
  int num_checks = 0;

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  fct_timer u_dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_standby(i_standby),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .i_external_count_input(i_ext),
    .i_capture_pin(i_cap),
    .o_rdata(rdata),
    .o_match_a_pin(pin_a),
    .o_match_b_pin(pin_b),
    .o_capture_irq(irq_c),
    .o_match_a_irq(irq_a),
    .o_match_b_irq(irq_b),
    .o_wrap_irq(irq_w)
  );

  fct_cpu_model u_cpu (
    .i_clk(i_clk),
    .i_rdata(rdata),
    .o_addr(addr),
    .o_wdata(wdata),
    .o_wr(wr),
    .o_rd(rd)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // replays n counting ticks; result is {wrap, match b, match a, count}
  function automatic logic [18:0] sim(input logic [15:0] st, input int k, input logic [15:0] a, input logic [15:0] b,
                                      input logic cl);
    logic [15:0] c;
    logic fa, fb, fw;
    c = st;
    fa = 1'b0;
    fb = 1'b0;
    fw = 1'b0;
    repeat (k) begin
      fa |= (c == a);
      fb |= (c == b);
      if (cl && c == a) begin
        c = 16'h0000;
      end else begin
        fw |= (c == 16'hffff);
        c = c + 16'h0001;
      end
    end
    return {fw, fb, fa, c};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_b(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_cpu.acc(1'b1, a, d, q);
  endtask

  task automatic rd_b(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_cpu.acc(1'b0, a, 8'h00, q);
    chk(16'(q), 16'(exp));
  endtask

  task automatic rd_w(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] q;
    u_cpu.rd16(a, q);
    chk(q, exp);
  endtask

  // capture pin moves only in steps that stay put for eight clocks
  task automatic pin_flip();
    @(negedge i_clk);
    i_cap = ~i_cap;
    repeat (8) @(negedge i_clk);
  endtask

  task automatic ext_pulses(input int k);
    repeat (k) begin
      @(negedge i_clk);
      i_ext = 1'b1;
      repeat (6) @(negedge i_clk);
      i_ext = 1'b0;
      repeat (6) @(negedge i_clk);
    end
  endtask

  task automatic chk_rst();
    rd_w(OFS_CNT_HI, 16'h0000);
    chk(16'({pin_a, pin_b, irq_c, irq_a, irq_b, irq_w}), 16'h0000);
    rd_b(OFS_IRQ_EN, 8'h01);
    rd_b(OFS_FLAGS, 8'h00);
    rd_b(OFS_TIMER_CTL, 8'h00);
    rd_b(OFS_OUT_CTL, 8'he0);
    rd_w(OFS_CMP_HI, 16'hffff);
    wr_b(OFS_OUT_CTL, 8'hf0);
    rd_w(OFS_CMP_HI, 16'hffff);
    u_cpu.wr16(OFS_CAP_HI, 16'hffff);
    rd_w(OFS_CAP_HI, 16'h0000);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    summarize();
  end

  initial begin
    i_rstn = 1'b0;
    i_standby = 1'b0;
    i_ext = 1'b0;
    i_cap = 1'b0;
    exp_pa = 1'b0;
    exp_pb = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    chk_rst();
    wr_b(OFS_IRQ_EN, 8'hff);
    rd_b(OFS_IRQ_EN, 8'h8f);
    wr_b(OFS_FLAGS, 8'hff);
    rd_b(OFS_FLAGS, 8'h01);
    wr_b(OFS_TIMER_CTL, 8'hff);
    rd_b(OFS_TIMER_CTL, 8'h83);
    // prescaled rates: 20 periods of each divider, prescaler phase unknown
    for (int k = 0; k < 3; k++) begin
      wr_b(OFS_TIMER_CTL, 8'(k));
      u_cpu.wr16(OFS_CNT_HI, 16'h0000);
      repeat (20 << (3 + 2 * k)) @(negedge i_clk);
      u_cpu.rd16(OFS_CNT_HI, q16);
      chk(16'(q16 >= 16'd19 && q16 <= 16'd21), 16'h0001);
    end
    // external counting keeps the count still between pulses, so every value is exact
    for (int it = 0; it < 12; it++) begin
      r = rnd();
      s = (it == 0) ? 16'hfffc : r[15:0];
      n = (it == 0) ? 8 : 1 + int'(r[18:16]);
      ca = s + 16'(r[21:19]);
      cb = s + 16'(r[24:22]) + 16'h0001;
      {clr, la, lb, e} = r[28:25];
      r = rnd();
      ie = r[7:0] & 8'h8e;
      wr_b(OFS_TIMER_CTL, {e, 7'h03});
      wr_b(OFS_OUT_CTL, {6'h3c, la, lb});
      u_cpu.wr16(OFS_CMP_HI, cb);
      wr_b(OFS_OUT_CTL, {6'h38, la, lb});
      u_cpu.wr16(OFS_CMP_HI, ca);
      wr_b(OFS_OUT_CTL, {6'h3c, la, lb});
      rd_w(OFS_CMP_HI, cb);
      wr_b(OFS_OUT_CTL, {6'h38, la, lb});
      rd_w(OFS_CMP_HI, ca);
      wr_b(OFS_IRQ_EN, ie);
      rd_b(OFS_IRQ_EN, ie | 8'h01);
      wr_b(OFS_FLAGS, {7'h00, clr});
      u_cpu.wr16(OFS_CNT_HI, s);
      hit = (e != i_cap);
      pin_flip();
      ext_pulses(n);
      pin_flip();
      x = sim(s, n, ca, cb, clr);
      rd_w(OFS_CNT_HI, x[15:0]);
      rd_w(OFS_CAP_HI, hit ? s : x[15:0]);
      fl = {4'h8, x[16], x[17], x[18], clr};
      if (x[16]) exp_pa = la;
      if (x[17]) exp_pb = lb;
      chk(16'({pin_a, pin_b}), 16'({exp_pa, exp_pb}));
      chk(16'({irq_c, irq_a, irq_b, irq_w}), 16'({fl[7], fl[3:1]} & {ie[7], ie[3:1]}));
      // unread flags must survive a zero write
      wr_b(OFS_FLAGS, {7'h00, clr});
      rd_b(OFS_FLAGS, fl);
      wr_b(OFS_FLAGS, {7'h00, clr});
      rd_b(OFS_FLAGS, {7'h00, clr});
    end
    // wrap landing on the clearing write: the set must win
    wr_b(OFS_TIMER_CTL, 8'h83);
    wr_b(OFS_FLAGS, 8'h00);
    u_cpu.wr16(OFS_CNT_HI, 16'hffff);
    ext_pulses(1);
    fl = {4'h0, ca == 16'hffff, cb == 16'hffff, 2'b10};
    rd_b(OFS_FLAGS, fl);
    u_cpu.wr16(OFS_CNT_HI, 16'hffff);
    fork
      ext_pulses(1);
      begin
        @(negedge i_clk);
        wr_b(OFS_FLAGS, 8'h00);
      end
    join
    rd_b(OFS_FLAGS, fl);
    // capture edge on an upper-byte capture read lands one cycle late
    q16 = hit ? s : x[15:0];
    u_cpu.wr16(OFS_CNT_HI, 16'h5a3c);
    fork
      rd_w(OFS_CAP_HI, q16);
      begin
        @(negedge i_clk);
        i_cap = 1'b1;
      end
    join
    rd_w(OFS_CAP_HI, 16'h5a3c);
    rd_b(OFS_FLAGS, fl | 8'h80);
    pin_flip();
    @(negedge i_clk);
    i_standby = 1'b1;
    repeat (2) @(negedge i_clk);
    i_standby = 1'b0;
    chk_rst();
    summarize();
  end
endmodule

// ---- verilog/fct_edge_det.sv ----
`timescale 1ns/10ps
module fct_edge_det (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_init,
  input wire logic i_rising,
  input wire logic i_pin,
  output logic o_edge
);
  logic prev;
  logic next_prev;

  // pulses shorter than the documented width may be missed
  always_comb begin
    next_prev = i_pin;
    o_edge = i_rising ? (i_pin & ~prev) : (~i_pin & prev);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_init) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule

// ---- verilog/fct_pkg.sv ----
package fct_pkg;
  // byte register indices on the 8-bit cpu port
  localparam logic [3:0] OFS_IRQ_EN = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h1;
  localparam logic [3:0] OFS_CNT_HI = 4'h2;
  localparam logic [3:0] OFS_CNT_LO = 4'h3;
  localparam logic [3:0] OFS_CMP_HI = 4'h4;
  localparam logic [3:0] OFS_CMP_LO = 4'h5;
  localparam logic [3:0] OFS_TIMER_CTL = 4'h6;
  localparam logic [3:0] OFS_OUT_CTL = 4'h7;
  localparam logic [3:0] OFS_CAP_HI = 4'h8;
  localparam logic [3:0] OFS_CAP_LO = 4'h9;
  // field positions
  localparam int BIT_CAPTURE = 7;
  localparam int BIT_MATCH_A = 3;
  localparam int BIT_MATCH_B = 2;
  localparam int BIT_WRAP = 1;
  localparam int BIT_CLEAR_A = 0;
  localparam int BIT_EDGE = 7;
  localparam int BIT_CMP_SEL = 4;
  localparam int BIT_LEVEL_A = 1;
  localparam int BIT_LEVEL_B = 0;
  // writable and fixed bits
  localparam logic [7:0] IRQ_EN_WMASK = 8'h8e;
  localparam logic [7:0] IRQ_EN_FIXED = 8'h01;
  localparam logic [7:0] FLAG_MASK = 8'h8e;
  localparam logic [7:0] TIMER_CTL_WMASK = 8'h83;
  localparam logic [7:0] OUT_CTL_WMASK = 8'h13;
  localparam logic [7:0] OUT_CTL_FIXED = 8'he0;
  // reset values
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hffff;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [7:0] RST_IRQ_EN = 8'h01;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_TIMER_CTL = 8'h00;
  localparam logic [7:0] RST_OUT_CTL = 8'he0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // prescaler ratios
  localparam int PRESCALE_BITS = 7;
  localparam logic [6:0] DIV8_LAST = 7'h07;
  localparam logic [6:0] DIV32_LAST = 7'h1f;
  localparam logic [6:0] DIV128_LAST = 7'h7f;
  // least pulse width on capture and count inputs, in system clocks
  localparam int MIN_PULSE_CYCLES = 6;
  typedef enum logic [1:0] {
    CKS_DIV8 = 2'b00,
    CKS_DIV32 = 2'b01,
    CKS_DIV128 = 2'b10,
    CKS_EXT = 2'b11
  } fct_clk_sel_t;
endpackage

// ---- verilog/fct_tick_gen.sv ----
`timescale 1ns/10ps
module fct_tick_gen (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_init,
  input wire fct_pkg::fct_clk_sel_t i_sel,
  input wire logic i_ext,
  output logic o_tick
);
  import fct_pkg::*;
  logic [PRESCALE_BITS-1:0] pre;
  logic ext_prev;
  logic [PRESCALE_BITS-1:0] next_pre;
  logic next_ext_prev;
  logic next_tick;

  always_comb begin
    next_pre = pre + 7'h01;
    next_ext_prev = i_ext;
    unique case (i_sel)
      CKS_DIV8: next_tick = (pre[2:0] == DIV8_LAST[2:0]);
      CKS_DIV32: next_tick = (pre[4:0] == DIV32_LAST[4:0]);
      CKS_DIV128: next_tick = (pre == DIV128_LAST);
      CKS_EXT: next_tick = i_ext & ~ext_prev;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_init) begin
      pre <= '0;
      ext_prev <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      pre <= next_pre;
      ext_prev <= next_ext_prev;
      o_tick <= next_tick;
    end
  end
endmodule

// ---- verilog/fct_timer.sv ----
// Functional notes
// - 16-bit counter advances on selected tick
// - wrap from all ones sets wrap flag
// - counter zeroed on reset and standby
// - both compares checked on each tick, set flags
// - match drives pin to channel level bit
// - compare pins low until first match
// - compare registers reset to all ones
// - selected capture edge copies count, sets flag
// - capture register read-only, reset to zero
// - clear-on-match-A bit clears counter on match
// - capture irq is flag and enable
// - match irqs are flag and enable
// - wrap irq is flag and enable
// - enables reset 0x01, fixed bits read
// - flags clear by read-one then write-zero
// - flags register resets zero, reserved read zero
// - word values pass through staging byte, except compare reads
// - upper byte first, lower commits or reads
// - edge select: 0 falling, 1 rising
// - clock select: /8, /32, /128, external
// - one address, select bit picks compare
`timescale 1ns/10ps
module fct_timer (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_standby,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_external_count_input,
  input wire logic i_capture_pin,
  output logic [7:0] o_rdata,
  output logic o_match_a_pin,
  output logic o_match_b_pin,
  output logic o_capture_irq,
  output logic o_match_a_irq,
  output logic o_match_b_irq,
  output logic o_wrap_irq
);
  import fct_pkg::*;

  logic [15:0] running_count;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] captured_count;
  logic [7:0] interrupt_enables;
  logic [7:0] flags_and_clear_control;
  logic [7:0] timer_control;
  logic [7:0] compare_output_control;
  logic [7:0] staging;
  logic [7:0] clear_armed;
  logic capture_held;

  logic [15:0] next_running_count;
  logic [15:0] next_compare_value_a;
  logic [15:0] next_compare_value_b;
  logic [15:0] next_captured_count;
  logic [7:0] next_interrupt_enables;
  logic [7:0] next_flags_and_clear_control;
  logic [7:0] next_timer_control;
  logic [7:0] next_compare_output_control;
  logic [7:0] next_staging;
  logic [7:0] next_clear_armed;
  logic next_capture_held;
  logic [7:0] next_rdata;
  logic next_match_a_pin;
  logic next_match_b_pin;

  logic init;
  logic tick;
  logic capture_edge;
  logic capture_event;
  logic match_a;
  logic match_b;
  logic clear_on_a;
  logic wrap;
  logic [7:0] hw_set;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs, input logic strobe);
    hit = strobe && (addr == ofs);
  endfunction

  assign init = i_standby;

  fct_tick_gen u_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_init(init),
    .i_sel(fct_clk_sel_t'(timer_control[1:0])),
    .i_ext(i_external_count_input),
    .o_tick(tick)
  );

  fct_edge_det u_edge (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_init(init),
    .i_rising(timer_control[BIT_EDGE]),
    .i_pin(i_capture_pin),
    .o_edge(capture_edge)
  );

  // match is taken on the tick that leaves the matching value
  assign match_a = tick && (running_count == compare_value_a);
  assign match_b = tick && (running_count == compare_value_b);
  assign clear_on_a = match_a && flags_and_clear_control[BIT_CLEAR_A];
  assign wrap = tick && (running_count == COUNT_MAX) && !clear_on_a;
  // a capture edge during an upper-byte read of the capture is held one cycle
  assign capture_event = (capture_edge && !hit(i_addr, OFS_CAP_HI, i_rd)) || capture_held;

  always_comb begin
    hw_set = 8'h00;
    hw_set[BIT_CAPTURE] = capture_event;
    hw_set[BIT_MATCH_A] = match_a;
    hw_set[BIT_MATCH_B] = match_b;
    hw_set[BIT_WRAP] = wrap;
  end

  // register file, counter and pins
  always_comb begin
    next_running_count = running_count;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_captured_count = captured_count;
    next_interrupt_enables = interrupt_enables;
    next_flags_and_clear_control = flags_and_clear_control;
    next_timer_control = timer_control;
    next_compare_output_control = compare_output_control;
    next_staging = staging;
    next_clear_armed = clear_armed;
    next_capture_held = capture_edge && hit(i_addr, OFS_CAP_HI, i_rd);
    next_rdata = o_rdata;
    next_match_a_pin = o_match_a_pin;
    next_match_b_pin = o_match_b_pin;

    if (clear_on_a) begin
      next_running_count = RST_COUNT;
    end else if (tick) begin
      next_running_count = running_count + 16'h0001;
    end
    if (match_a) begin
      next_match_a_pin = compare_output_control[BIT_LEVEL_A];
    end
    if (match_b) begin
      next_match_b_pin = compare_output_control[BIT_LEVEL_B];
    end
    if (capture_event) begin
      next_captured_count = running_count;
    end

    if (i_wr) begin
      unique case (i_addr)
        OFS_IRQ_EN: next_interrupt_enables = (i_wdata & IRQ_EN_WMASK) | IRQ_EN_FIXED;
        OFS_FLAGS: next_flags_and_clear_control[BIT_CLEAR_A] = i_wdata[BIT_CLEAR_A];
        OFS_TIMER_CTL: next_timer_control = i_wdata & TIMER_CTL_WMASK;
        OFS_OUT_CTL: next_compare_output_control = (i_wdata & OUT_CTL_WMASK) | OUT_CTL_FIXED;
        OFS_CNT_HI, OFS_CMP_HI: next_staging = i_wdata;
        OFS_CNT_LO: next_running_count = {staging, i_wdata};
        OFS_CMP_LO: begin
          if (compare_output_control[BIT_CMP_SEL]) begin
            next_compare_value_b = {staging, i_wdata};
          end else begin
            next_compare_value_a = {staging, i_wdata};
          end
        end
        default: ; // capture is read-only
      endcase
    end

    if (i_rd) begin
      unique case (i_addr)
        OFS_IRQ_EN: next_rdata = interrupt_enables;
        OFS_FLAGS: next_rdata = flags_and_clear_control;
        OFS_TIMER_CTL: next_rdata = timer_control;
        OFS_OUT_CTL: next_rdata = compare_output_control;
        OFS_CNT_HI: begin
          next_rdata = running_count[15:8];
          next_staging = running_count[7:0];
        end
        OFS_CAP_HI: begin
          next_rdata = captured_count[15:8];
          next_staging = captured_count[7:0];
        end
        OFS_CNT_LO, OFS_CAP_LO: next_rdata = staging;
        // compare reads go straight out, no staging
        OFS_CMP_HI: next_rdata = compare_output_control[BIT_CMP_SEL] ? compare_value_b[15:8]
                                                                    : compare_value_a[15:8];
        OFS_CMP_LO: next_rdata = compare_output_control[BIT_CMP_SEL] ? compare_value_b[7:0]
                                                                    : compare_value_a[7:0];
        default: next_rdata = 8'h00;
      endcase
    end

    for (int i = 1; i < 8; i++) begin
      if (FLAG_MASK[i]) begin
        if (hit(i_addr, OFS_FLAGS, i_rd) && flags_and_clear_control[i]) begin
          next_clear_armed[i] = 1'b1;
        end
        if (hit(i_addr, OFS_FLAGS, i_wr)) begin
          if (!i_wdata[i] && clear_armed[i]) begin
            next_flags_and_clear_control[i] = 1'b0;
          end
          next_clear_armed[i] = 1'b0;
        end
        if (hw_set[i]) begin
          next_flags_and_clear_control[i] = 1'b1; // set wins
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || init) begin
      running_count <= RST_COUNT;
      compare_value_a <= RST_COMPARE;
      compare_value_b <= RST_COMPARE;
      captured_count <= RST_CAPTURE;
      interrupt_enables <= RST_IRQ_EN;
      flags_and_clear_control <= RST_FLAGS;
      timer_control <= RST_TIMER_CTL;
      compare_output_control <= RST_OUT_CTL;
      staging <= 8'h00;
      clear_armed <= 8'h00;
      capture_held <= 1'b0;
      o_rdata <= 8'h00;
      o_match_a_pin <= 1'b0;
      o_match_b_pin <= 1'b0;
      o_capture_irq <= 1'b0;
      o_match_a_irq <= 1'b0;
      o_match_b_irq <= 1'b0;
      o_wrap_irq <= 1'b0;
    end else begin
      running_count <= next_running_count;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      captured_count <= next_captured_count;
      interrupt_enables <= next_interrupt_enables;
      flags_and_clear_control <= next_flags_and_clear_control;
      timer_control <= next_timer_control;
      compare_output_control <= next_compare_output_control;
      staging <= next_staging;
      clear_armed <= next_clear_armed;
      capture_held <= next_capture_held;
      o_rdata <= next_rdata;
      o_match_a_pin <= next_match_a_pin;
      o_match_b_pin <= next_match_b_pin;
      // registered from next values so irq tracks flag and enable exactly
      o_capture_irq <= next_flags_and_clear_control[BIT_CAPTURE] & next_interrupt_enables[BIT_CAPTURE];
      o_match_a_irq <= next_flags_and_clear_control[BIT_MATCH_A] & next_interrupt_enables[BIT_MATCH_A];
      o_match_b_irq <= next_flags_and_clear_control[BIT_MATCH_B] & next_interrupt_enables[BIT_MATCH_B];
      o_wrap_irq <= next_flags_and_clear_control[BIT_WRAP] & next_interrupt_enables[BIT_WRAP];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn || i_standby);

  sequence s_read_count_hi;
    i_rd && !i_wr && (i_addr == OFS_CNT_HI);
  endsequence
  sequence s_read_count_lo;
    i_rd && !i_wr && (i_addr == OFS_CNT_LO);
  endsequence
  sequence s_capture_on_read;
    capture_edge && hit(i_addr, OFS_CAP_HI, i_rd);
  endsequence

  a_count_advance: assert property (tick && !clear_on_a && !i_wr |=>
    running_count == $past(running_count) + 16'h0001) else $error("counter did not advance on tick");
  a_wrap_flag_set: assert property (wrap |=> flags_and_clear_control[BIT_WRAP] ##0
    running_count == RST_COUNT || $past(i_wr)) else $error("wrap did not set flag");
  a_clear_on_match: assert property (clear_on_a && !i_wr |=> running_count == RST_COUNT)
    else $error("match A did not clear counter");
  a_match_pin_level: assert property (match_a |=>
    o_match_a_pin == $past(compare_output_control[BIT_LEVEL_A])) else $error("pin A level wrong");
  a_capture_copy: assert property (capture_event |=>
    captured_count == $past(running_count) && flags_and_clear_control[BIT_CAPTURE])
    else $error("capture did not latch count");
  a_capture_irq_level: assert property (o_capture_irq ==
    (flags_and_clear_control[BIT_CAPTURE] && interrupt_enables[BIT_CAPTURE])) else $error("capture irq wrong");
  a_match_irq_level: assert property (o_match_a_irq ==
    (flags_and_clear_control[BIT_MATCH_A] && interrupt_enables[BIT_MATCH_A])) else $error("match irq wrong");
  a_wrap_irq_level: assert property (o_wrap_irq ==
    (flags_and_clear_control[BIT_WRAP] && interrupt_enables[BIT_WRAP])) else $error("wrap irq wrong");
  a_enable_fixed_bits: assert property (i_rd && !i_wr && i_addr == OFS_IRQ_EN |=>
    o_rdata[0] && o_rdata[6:4] == 3'b000) else $error("enable fixed bits wrong");
  a_set_beats_clear: assert property (wrap && hit(i_addr, OFS_FLAGS, i_wr) |=>
    flags_and_clear_control[BIT_WRAP]) else $error("clear beat hardware set");
  a_flag_no_sw_set: assert property (!flags_and_clear_control[BIT_MATCH_B] && !match_b |=>
    !flags_and_clear_control[BIT_MATCH_B]) else $error("software set a flag");
  a_word_read_pair: assert property (s_read_count_hi ##1 s_read_count_lo |=>
    o_rdata == $past(running_count[7:0], 2)) else $error("low byte not from staging");
  a_match_b_pin: assert property (match_b |=>
    o_match_b_pin == $past(compare_output_control[BIT_LEVEL_B])) else $error("pin B level wrong");
  a_match_b_irq: assert property (o_match_b_irq ==
    (flags_and_clear_control[BIT_MATCH_B] && interrupt_enables[BIT_MATCH_B])) else $error("match B irq wrong");
  a_match_flag_set: assert property (match_a |=>
    flags_and_clear_control[BIT_MATCH_A]) else $error("match A did not set flag");
  // capture is held back while the upper byte goes out, so the pair stays coherent
  a_capture_deferred: assert property (s_capture_on_read |=>
    captured_count == $past(captured_count) ##1 captured_count == $past(running_count))
    else $error("deferred capture wrong");
endmodule
